// ===== rtl/baud_gen_pkg.sv
// Shared constants and types of the serial channel baud rate generator
package baud_gen_pkg;

  localparam int ADDR_WIDTH     = 3;
  localparam int DATA_WIDTH     = 8;
  localparam int PRESCALE_WIDTH = 10;
  localparam int DIVIDE_WIDTH   = 8;
  localparam int SELECT_WIDTH   = 4;
  localparam int CHANNELS       = 2;
  localparam int TX_INDEX       = 0;
  localparam int RX_INDEX       = 1;

  // Register offsets
  localparam logic [ADDR_WIDTH-1:0] SELECT_OFFSET  = 3'h0;
  localparam logic [ADDR_WIDTH-1:0] DIVIDER_OFFSET = 3'h1;
  localparam logic [ADDR_WIDTH-1:0] CONTROL_OFFSET = 3'h2;
  localparam logic [ADDR_WIDTH-1:0] STATUS_OFFSET  = 3'h3;

  // Reset values
  localparam logic [SELECT_WIDTH-1:0] SELECT_RESET  = 4'h0;
  localparam logic [DIVIDE_WIDTH-1:0] DIVIDER_RESET = 8'hFF;
  localparam logic                    CONTROL_RESET = 1'b0;

  // Select codes and divide limits
  localparam logic [SELECT_WIDTH-1:0] MAX_DIVIDE_CODE = 4'hA;
  localparam logic [SELECT_WIDTH-1:0] EXT_CLOCK_CODE  = 4'hB;
  localparam logic [DIVIDE_WIDTH-1:0] MIN_DIVIDE      = 8'h04;

  // Control register fields
  localparam int CTRL_POWER_BIT = 7;
  localparam int CTRL_TXE_BIT   = 6;
  localparam int CTRL_RXE_BIT   = 5;

  // Status register fields
  localparam int ST_SELECT_BAD    = 0;
  localparam int ST_DIVIDE_BAD    = 1;
  localparam int ST_SEL_WHILE_ON  = 2;
  localparam int ST_DIV_WHILE_RUN = 3;
  localparam int ST_TX_BAUD       = 4;
  localparam int ST_RX_BAUD       = 5;
  localparam int ST_TX_RUN        = 6;
  localparam int ST_RX_RUN        = 7;

  typedef struct packed {
    logic power;
    logic tx_enable;
    logic rx_enable;
  } control_type;

  typedef struct packed {
    logic                  write;
    logic                  read;
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] data;
  } bus_req_type;

endpackage

// ===== rtl/base_clock_prescaler.sv
// Base clock selector: main clock divided by 2^m or external pin edges
`timescale 1ns/100ps
module base_clock_prescaler import baud_gen_pkg::*; #(
  parameter bit EXT_ALLOWED = 1'b1
) (
  input  wire logic                    i_sys_clk,
  input  wire logic                    i_reset_n,
  input  wire logic                    i_clk_en,
  input  wire logic                    i_power,
  input  wire logic [SELECT_WIDTH-1:0] i_select,
  input  wire logic                    i_ext_pin,
  output logic                         o_base_tick,
  output logic                         o_select_bad
);

  localparam logic [PRESCALE_WIDTH-1:0] UNIT = 1;

  logic [PRESCALE_WIDTH-1:0] count;
  logic [PRESCALE_WIDTH-1:0] mask;
  logic                      ext_q;
  wire                       all_ones;
  wire                       div_code;
  wire                       ext_code;
  wire                       ext_rise;

  // Bit g of the prescaler matters once the code exceeds g
  for (genvar g = 0; g < PRESCALE_WIDTH; g++) begin : g_mask
    assign mask[g] = i_select > SELECT_WIDTH'(g);
  end

  assign all_ones     = &(count | ~mask);
  assign div_code     = i_select <= MAX_DIVIDE_CODE;
  assign ext_code     = EXT_ALLOWED && (i_select == EXT_CLOCK_CODE);
  assign ext_rise     = i_ext_pin & ~ext_q;
  assign o_select_bad = !(div_code || ext_code);
  // Prohibited codes stop the base clock rather than picking a guess
  assign o_base_tick  = i_power && i_clk_en &&
                        ((div_code && all_ones) || (ext_code && ext_rise));

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count <= '0;
      ext_q <= 1'b0;
    end else if (i_clk_en) begin
      ext_q <= i_ext_pin;
      count <= i_power ? count + UNIT : '0;
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_code0_every_cycle;
    (i_power && i_clk_en && i_select == SELECT_RESET) |-> o_base_tick;
  endproperty
  a_code0_every_cycle: assert property (p_code0_every_cycle)
    else $error("divide-by-one base clock missed a cycle");

  property p_ext_blocked;
    (!EXT_ALLOWED && i_select == EXT_CLOCK_CODE) |-> !o_base_tick;
  endproperty
  a_ext_blocked: assert property (p_ext_blocked)
    else $error("external clock used where it is not allowed");

  property p_code1_alternates;
    (i_power && i_clk_en && i_select == UNIT[SELECT_WIDTH-1:0] && o_base_tick)
      ##1 (i_power && i_clk_en && i_select == UNIT[SELECT_WIDTH-1:0]) |-> !o_base_tick;
  endproperty
  a_code1_alternates: assert property (p_code1_alternates)
    else $error("divide-by-two base clock ticked twice in a row");

endmodule

// ===== rtl/divide_counter.sv
// Programmable divide-by-k counter producing serial tick and baud clock
`timescale 1ns/100ps
module divide_counter import baud_gen_pkg::*; #(
  parameter int WIDTH = DIVIDE_WIDTH
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clk_en,
  input  wire logic             i_enable,
  input  wire logic             i_tick,
  input  wire logic [WIDTH-1:0] i_divide,
  output logic                  o_serial_tick,
  output logic                  o_baud_clk,
  output logic                  o_divide_bad
);

  localparam logic [WIDTH-1:0] UNIT = 1;

  logic [WIDTH-1:0] count;
  logic [WIDTH:0]   ticks_seen;
  wire              legal;
  wire              step;
  wire              hit;

  assign legal        = i_divide >= WIDTH'(MIN_DIVIDE);
  assign o_divide_bad = !legal;
  assign step         = i_clk_en && i_enable && legal && i_tick;
  // >= lets the count recover at once if k is lowered mid-count
  assign hit          = step && (count >= i_divide - UNIT);

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      count         <= '0;
      o_baud_clk    <= 1'b0;
      o_serial_tick <= 1'b0;
    end else if (i_clk_en) begin
      o_serial_tick <= hit;
      if (!i_enable) begin
        count      <= '0;
        o_baud_clk <= 1'b0;
      end else if (step) begin
        count <= hit ? '0 : count + UNIT;
        if (hit) begin
          o_baud_clk <= ~o_baud_clk;
        end
      end
    end
  end

  // Helper: base ticks counted since the last serial pulse
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      ticks_seen <= '0;
    end else if (i_clk_en) begin
      if (!i_enable || hit) begin
        ticks_seen <= '0;
      end else if (step) begin
        ticks_seen <= ticks_seen + (WIDTH+1)'(UNIT);
      end
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_k_spacing;
    (hit && $stable(i_divide)) |-> (ticks_seen + (WIDTH+1)'(UNIT) == {1'b0, i_divide});
  endproperty
  a_k_spacing: assert property (p_k_spacing)
    else $error("serial pulse not after k base ticks");

  property p_baud_toggles;
    hit |=> (o_baud_clk != $past(o_baud_clk)) && o_serial_tick;
  endproperty
  a_baud_toggles: assert property (p_baud_toggles)
    else $error("baud clock did not toggle on serial pulse");

  property p_baud_holds;
    (i_clk_en && i_enable && !hit) |=> $stable(o_baud_clk);
  endproperty
  a_baud_holds: assert property (p_baud_holds)
    else $error("baud clock moved without a serial pulse");

  property p_illegal_k;
    !legal |-> !hit;
  endproperty
  a_illegal_k: assert property (p_illegal_k)
    else $error("serial pulse with prohibited divide value");

endmodule

// ===== rtl/uart_baud_rate_generator.sv
// Baud rate generator of one serial channel with its register port
`timescale 1ns/100ps
module uart_baud_rate_generator import baud_gen_pkg::*; #(
  parameter bit EXT_CLOCK_ALLOWED = 1'b1
) (
  input  wire logic                  i_sys_clk,
  input  wire logic                  i_reset_n,
  input  wire logic                  i_clk_en,
  input  wire logic [ADDR_WIDTH-1:0] i_addr,
  input  wire logic [DATA_WIDTH-1:0] i_wr_data,
  input  wire logic                  i_wr_strobe,
  input  wire logic                  i_rd_strobe,
  output logic      [DATA_WIDTH-1:0] o_rd_data,
  input  wire logic                  i_external_baud_clock_pin,
  output logic                       o_channel_power,
  output logic                       o_transmit_enable,
  output logic                       o_receive_enable,
  output logic                       o_tx_serial_tick,
  output logic                       o_tx_baud_clk,
  output logic                       o_rx_serial_tick,
  output logic                       o_rx_baud_clk
);

  bus_req_type               req;
  control_type               control;
  logic [SELECT_WIDTH-1:0]   select;
  logic [DIVIDE_WIDTH-1:0]   divider;
  logic                      sel_while_on;
  logic                      div_while_run;
  logic [CHANNELS-1:0]       channel_enable;
  logic [CHANNELS-1:0]       serial_tick;
  logic [CHANNELS-1:0]       baud_clk;
  logic [CHANNELS-1:0]       divide_bad;
  logic                      base_tick;
  logic                      select_bad;
  logic [DATA_WIDTH-1:0]     status_value;
  logic [DATA_WIDTH-1:0]     control_value;
  logic [DATA_WIDTH-1:0]     read_value;
  logic                      select_written;
  logic                      divider_written;

  assign req.write = i_wr_strobe;
  assign req.read  = i_rd_strobe;
  assign req.addr  = i_addr;
  assign req.data  = i_wr_data;

  // Address decode
  wire hit_select  = req.addr == SELECT_OFFSET;
  wire hit_divider = req.addr == DIVIDER_OFFSET;
  wire hit_control = req.addr == CONTROL_OFFSET;
  wire hit_status  = req.addr == STATUS_OFFSET;
  wire wr_select   = i_clk_en && req.write && hit_select;
  wire wr_divider  = i_clk_en && req.write && hit_divider;
  wire wr_control  = i_clk_en && req.write && hit_control;
  wire wr_status   = i_clk_en && req.write && hit_status;

  // Writes that break the software sequence are flagged, never blocked,
  // so a misbehaving driver still sees the value it wrote.
  wire counters_running = control.tx_enable || control.rx_enable;
  wire set_sel_while_on = wr_select && control.power;
  wire set_div_while_run = wr_divider && control.power && counters_running;
  wire clr_sel_while_on = wr_status && req.data[ST_SEL_WHILE_ON];
  wire clr_div_while_run = wr_status && req.data[ST_DIV_WHILE_RUN];

  // Register file
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      select  <= SELECT_RESET;
      divider <= DIVIDER_RESET;
    end else begin
      if (wr_select) begin
        select <= req.data[SELECT_WIDTH-1:0];
      end
      if (wr_divider) begin
        divider <= req.data;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      control.power     <= CONTROL_RESET;
      control.tx_enable <= CONTROL_RESET;
      control.rx_enable <= CONTROL_RESET;
    end else if (wr_control) begin
      control.power     <= req.data[CTRL_POWER_BIT];
      control.tx_enable <= req.data[CTRL_TXE_BIT];
      control.rx_enable <= req.data[CTRL_RXE_BIT];
    end
  end

  // Sticky sequence flags: a new violation beats a clear in the same cycle
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      sel_while_on  <= 1'b0;
      div_while_run <= 1'b0;
    end else begin
      if (set_sel_while_on) begin
        sel_while_on <= 1'b1;
      end else if (clr_sel_while_on) begin
        sel_while_on <= 1'b0;
      end
      if (set_div_while_run) begin
        div_while_run <= 1'b1;
      end else if (clr_div_while_run) begin
        div_while_run <= 1'b0;
      end
    end
  end

  // Readback views
  assign control_value = {control.power, control.tx_enable, control.rx_enable, 5'h00};
  assign status_value[ST_SELECT_BAD]    = select_bad;
  assign status_value[ST_DIVIDE_BAD]    = divide_bad[TX_INDEX] | divide_bad[RX_INDEX];
  assign status_value[ST_SEL_WHILE_ON]  = sel_while_on;
  assign status_value[ST_DIV_WHILE_RUN] = div_while_run;
  assign status_value[ST_TX_BAUD]       = baud_clk[TX_INDEX];
  assign status_value[ST_RX_BAUD]       = baud_clk[RX_INDEX];
  assign status_value[ST_TX_RUN]        = channel_enable[TX_INDEX];
  assign status_value[ST_RX_RUN]        = channel_enable[RX_INDEX];

  // Upper nibble of the select register reads as zero
  assign read_value = hit_select  ? {4'h0, select} :
                      hit_divider ? divider :
                      hit_control ? control_value :
                      hit_status  ? status_value :
                      8'h00;

  // Read data stand only until the next enabled edge after the one that takes the strobe
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_rd_data <= 8'h00;
    end else if (i_clk_en) begin
      o_rd_data <= req.read ? read_value : 8'h00;
    end
  end

  // Base clock shared by both counters
  base_clock_prescaler #(
    .EXT_ALLOWED (EXT_CLOCK_ALLOWED)
  ) u_prescaler (
    .i_sys_clk    (i_sys_clk),
    .i_reset_n    (i_reset_n),
    .i_clk_en     (i_clk_en),
    .i_power      (control.power),
    .i_select     (select),
    .i_ext_pin    (i_external_baud_clock_pin),
    .o_base_tick  (base_tick),
    .o_select_bad (select_bad)
  );

  // Transmit and receive each own a counter so neither disturbs the other
  assign channel_enable[TX_INDEX] = control.power && control.tx_enable;
  assign channel_enable[RX_INDEX] = control.power && control.rx_enable;

  for (genvar c = 0; c < CHANNELS; c++) begin : g_counter
    divide_counter #(
      .WIDTH (DIVIDE_WIDTH)
    ) u_counter (
      .i_sys_clk     (i_sys_clk),
      .i_reset_n     (i_reset_n),
      .i_clk_en      (i_clk_en),
      .i_enable      (channel_enable[c]),
      .i_tick        (base_tick),
      .i_divide      (divider),
      .o_serial_tick (serial_tick[c]),
      .o_baud_clk    (baud_clk[c]),
      .o_divide_bad  (divide_bad[c])
    );
  end

  assign o_channel_power   = control.power;
  assign o_transmit_enable = channel_enable[TX_INDEX];
  assign o_receive_enable  = channel_enable[RX_INDEX];
  assign o_tx_serial_tick  = serial_tick[TX_INDEX];
  assign o_tx_baud_clk     = baud_clk[TX_INDEX];
  assign o_rx_serial_tick  = serial_tick[RX_INDEX];
  assign o_rx_baud_clk     = baud_clk[RX_INDEX];

  // Helpers: has a register been written since reset
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      select_written  <= 1'b0;
      divider_written <= 1'b0;
    end else begin
      if (wr_select) begin
        select_written <= 1'b1;
      end
      if (wr_divider) begin
        divider_written <= 1'b1;
      end
    end
  end

  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  property p_no_tick_unpowered;
    !control.power |-> !base_tick;
  endproperty
  a_no_tick_unpowered: assert property (p_no_tick_unpowered)
    else $error("base clock reached counters with power off");

  property p_unpowered_quiet;
    (!control.power && i_clk_en) ##1 !control.power |-> !o_tx_serial_tick && !o_rx_serial_tick;
  endproperty
  a_unpowered_quiet: assert property (p_unpowered_quiet)
    else $error("serial pulse while channel unpowered");

  property p_bad_select_stops;
    select_bad |-> !base_tick;
  endproperty
  a_bad_select_stops: assert property (p_bad_select_stops)
    else $error("prohibited select code produced a base tick");

  property p_select_readback;
    (i_clk_en && req.read && hit_select) |=> o_rd_data == {4'h0, $past(select)};
  endproperty
  a_select_readback: assert property (p_select_readback)
    else $error("select register readback wrong");

  property p_select_reset;
    (i_clk_en && req.read && hit_select && !select_written) |=> o_rd_data == 8'h00;
  endproperty
  a_select_reset: assert property (p_select_reset)
    else $error("select register not at reset value");

  property p_divider_reset;
    (i_clk_en && req.read && hit_divider && !divider_written) |=> o_rd_data == DIVIDER_RESET;
  endproperty
  a_divider_reset: assert property (p_divider_reset)
    else $error("divider register not at reset value");

  property p_divider_write_read;
    (wr_divider ##1 (i_clk_en && req.read && hit_divider && !req.write))
      |=> o_rd_data == $past(req.data, 2);
  endproperty
  a_divider_write_read: assert property (p_divider_write_read)
    else $error("divider write not read back");

  property p_tx_independent;
    (i_clk_en && !channel_enable[TX_INDEX]) |=> !o_tx_serial_tick;
  endproperty
  a_tx_independent: assert property (p_tx_independent)
    else $error("transmit counter pulsed while disabled");

  property p_rx_independent;
    (i_clk_en && !channel_enable[RX_INDEX]) |=> !o_rx_serial_tick;
  endproperty
  a_rx_independent: assert property (p_rx_independent)
    else $error("receive counter pulsed while disabled");

  property p_sel_flag_set;
    set_sel_while_on |=> sel_while_on;
  endproperty
  a_sel_flag_set: assert property (p_sel_flag_set)
    else $error("select write while powered not flagged");

  property p_div_flag_set;
    set_div_while_run |=> div_while_run;
  endproperty
  a_div_flag_set: assert property (p_div_flag_set)
    else $error("divider write while running not flagged");

  property p_sel_flag_clear;
    (clr_sel_while_on && !set_sel_while_on) |=> !sel_while_on;
  endproperty
  a_sel_flag_clear: assert property (p_sel_flag_clear)
    else $error("select sequence flag not cleared");

  property p_div_flag_clear;
    (clr_div_while_run && !set_div_while_run) |=> !div_while_run;
  endproperty
  a_div_flag_clear: assert property (p_div_flag_clear)
    else $error("divider sequence flag not cleared");

  property p_select_write;
    wr_select |=> select == $past(req.data[SELECT_WIDTH-1:0]);
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("select write did not land");

  property p_divider_readback;
    (i_clk_en && req.read && hit_divider) |=> o_rd_data == $past(divider);
  endproperty
  a_divider_readback: assert property (p_divider_readback)
    else $error("divider register readback wrong");

  property p_tx_baud_low;
    (i_clk_en && !channel_enable[TX_INDEX]) |=> !o_tx_baud_clk;
  endproperty
  a_tx_baud_low: assert property (p_tx_baud_low)
    else $error("transmit baud clock not low while disabled");

  c_tx_baud_rise: cover property ($rose(o_tx_baud_clk));
  c_rx_baud_rise: cover property ($rose(o_rx_baud_clk));
  c_ext_tick: cover property (base_tick && select == EXT_CLOCK_CODE);
  c_div_flag: cover property (set_div_while_run);

endmodule

// ===== verification/shift_logic_model.sv
// Model of the transmit and receive shift logic that consumes the baud clocks
`timescale 1ns/100ps
module shift_logic_model (
  input  wire logic             i_sys_clk,
  input  wire logic             i_reset_n,
  input  wire logic             i_clear,
  input  wire logic [1:0]       i_tick,
  input  wire logic [1:0]       i_baud,
  output logic      [1:0][15:0] o_count,
  output logic      [1:0][15:0] o_gap,
  output logic      [1:0]       o_baud_bad
);
  logic [1:0][15:0] since;

  // Index 0 is the transmit side, index 1 the receive side; they never share state
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_count    <= '0;
      o_gap      <= '0;
      o_baud_bad <= '0;
      since      <= '0;
    end else if (i_clear) begin
      o_count    <= '0;
      o_gap      <= '0;
      o_baud_bad <= '0;
      since      <= '0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        since[c] <= since[c] + 16'h0001;
        if (i_tick[c]) begin
          o_count[c] <= o_count[c] + 16'h0001;
          o_gap[c]   <= since[c] + 16'h0001;
          since[c]   <= 16'h0000;
          // Baud level after n pulses from a fresh start is the parity of n
          if (i_baud[c] !== ~o_count[c][0]) begin
            o_baud_bad[c] <= 1'b1;
          end
        end
      end
    end
  end
endmodule

// ===== verification/uart_baud_rate_generator_tb_top.sv
// Self-checking testbench of the serial channel baud rate generator
`timescale 1ns/100ps
module uart_baud_rate_generator_tb_top import baud_gen_pkg::*;;
  logic                  i_sys_clk;
  logic                  i_reset_n;
  logic                  i_clk_en;
  logic                  i_wr_strobe;
  logic                  i_rd_strobe;
  logic [ADDR_WIDTH-1:0] i_addr;
  logic [DATA_WIDTH-1:0] i_wr_data;
  logic [DATA_WIDTH-1:0] o_rd_data;
  logic                  pin;
  logic                  clr;
  logic                  power;
  logic                  tx_en;
  logic                  rx_en;
  logic                  ext_tick;
  logic [2:0]            pin_phase;
  logic [15:0]           ext_count;
  logic [1:0]            tick;
  logic [1:0]            baud;
  logic [1:0]            bad;
  logic [1:0][15:0]      cnt;
  logic [1:0][15:0]      gap;
  logic [11:0]           sk;
  int                    err_count;
  int                    checks_done;
  // Last two entries are prohibited settings: select code 12, then divide value 3
  logic [7:0]  sel_t [7] = '{8'h00, 8'h01, 8'h0A, 8'h03, 8'h0B, 8'h0C, 8'h00};
  logic [7:0]  div_t [7] = '{8'h04, 8'hFF, 8'h04, 8'h06, 8'h05, 8'h04, 8'h03};
  logic [7:0]  ctl_t [7] = '{8'hE0, 8'hC0, 8'hA0, 8'hE0, 8'hE0, 8'hE0, 8'hE0};
  logic [15:0] gap_t [7] = '{16'h0004, 16'h01FE, 16'h1000, 16'h0030, 16'h001E, 16'h0000,
                             16'h0000};

  uart_baud_rate_generator uart_baud_rate_generator_i (
    .i_sys_clk                 (i_sys_clk),
    .i_reset_n                 (i_reset_n),
    .i_clk_en                  (i_clk_en),
    .i_addr                    (i_addr),
    .i_wr_data                 (i_wr_data),
    .i_wr_strobe               (i_wr_strobe),
    .i_rd_strobe               (i_rd_strobe),
    .o_rd_data                 (o_rd_data),
    .i_external_baud_clock_pin (pin),
    .o_channel_power           (power),
    .o_transmit_enable         (tx_en),
    .o_receive_enable          (rx_en),
    .o_tx_serial_tick          (tick[TX_INDEX]),
    .o_tx_baud_clk             (baud[TX_INDEX]),
    .o_rx_serial_tick          (tick[RX_INDEX]),
    .o_rx_baud_clk             (baud[RX_INDEX])
  );

  // A channel without the pin clock must refuse select code 11
  uart_baud_rate_generator #(.EXT_CLOCK_ALLOWED(1'b0)) uart_baud_rate_generator_i2 (
    .i_sys_clk                 (i_sys_clk),
    .i_reset_n                 (i_reset_n),
    .i_clk_en                  (i_clk_en),
    .i_addr                    (i_addr),
    .i_wr_data                 (i_wr_data),
    .i_wr_strobe               (i_wr_strobe),
    .i_rd_strobe               (i_rd_strobe),
    .o_rd_data                 (),
    .i_external_baud_clock_pin (pin),
    .o_channel_power           (),
    .o_transmit_enable         (),
    .o_receive_enable          (),
    .o_tx_serial_tick          (ext_tick),
    .o_tx_baud_clk             (),
    .o_rx_serial_tick          (),
    .o_rx_baud_clk             ()
  );

  shift_logic_model shift_logic_model_i (
    .i_sys_clk  (i_sys_clk),
    .i_reset_n  (i_reset_n),
    .i_clear    (clr),
    .i_tick     (tick),
    .i_baud     (baud),
    .o_count    (cnt),
    .o_gap      (gap),
    .o_baud_bad (bad)
  );

  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end

  // Pin clock with a rising edge every 6 cycles
  always @(posedge i_sys_clk) begin
    if (!i_reset_n) begin
      pin_phase <= 3'h0;
      pin       <= 1'b0;
    end else begin
      pin_phase <= (pin_phase == 3'h5) ? 3'h0 : pin_phase + 3'h1;
      pin       <= (pin_phase < 3'h3);
    end
  end

  always @(posedge i_sys_clk) begin
    if (!i_reset_n || clr) begin
      ext_count <= 16'h0000;
    end else if (ext_tick === 1'b1) begin
      ext_count <= ext_count + 16'h0001;
    end
  end

  task automatic results();
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] exp, input logic [15:0] act);
    checks_done++;
    if (act !== exp) begin
      err_count++;
      $display("Error at %0t: expected %h got %h", $time, exp, act);
    end
  endtask

  task automatic wr(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] d);
    @(posedge i_sys_clk);
    i_wr_strobe <= 1'b1;
    i_addr      <= a;
    i_wr_data   <= d;
    @(posedge i_sys_clk);
    i_wr_strobe <= 1'b0;
  endtask

  // Called on an edge, so a read may follow a write with no gap; data sampled at cycle end
  task automatic rd(input logic [ADDR_WIDTH-1:0] a, input logic [DATA_WIDTH-1:0] e);
    i_rd_strobe <= 1'b1;
    i_addr      <= a;
    @(posedge i_sys_clk);
    i_rd_strobe <= 1'b0;
    @(posedge i_sys_clk);
    chk({8'h00, e}, {8'h00, o_rd_data});
  endtask

  // Power goes off before select and divider change, as software must do
  task automatic setup(input logic [7:0] s, input logic [7:0] k, input logic [7:0] c);
    wr(CONTROL_OFFSET, 8'h00);
    wr(SELECT_OFFSET, s);
    wr(DIVIDER_OFFSET, k);
    @(posedge i_sys_clk);
    clr <= 1'b1;
    @(posedge i_sys_clk);
    clr <= 1'b0;
    wr(CONTROL_OFFSET, c);
    @(posedge i_sys_clk);
  endtask

  task automatic wait_ticks(input int ch);
    int n;
    n = 0;
    while (cnt[ch] < 16'h0003 && n < 20000) begin
      @(posedge i_sys_clk);
      n++;
    end
    if (n >= 20000) begin
      err_count++;
      $display("Error at %0t: timeout expected %h got %h", $time, 16'h0003, cnt[ch]);
      results();
    end
  endtask

  // Software choice of m and k for a main clock to twice-baud ratio, k kept with ten fraction bits
  function automatic logic [11:0] pick(input int ratio);
    int m;
    int kx;
    m  = 0;
    kx = ratio * 1024;
    while (kx >= 256 * 1024) begin
      kx = kx / 2;
      m++;
    end
    kx = (kx + 512) / 1024;
    if (kx == 256) begin
      kx = 128;
      m++;
    end
    return {4'(m), 8'(kx)};
  endfunction

  initial begin
    i_reset_n   = 1'b0;
    i_clk_en    = 1'b1;
    i_wr_strobe = 1'b0;
    i_rd_strobe = 1'b0;
    i_addr      = '0;
    i_wr_data   = '0;
    clr         = 1'b0;
    err_count   = 0;
    checks_done = 0;
    repeat (6) @(posedge i_sys_clk);
    i_reset_n <= 1'b1;
    rd(SELECT_OFFSET, 8'h00);
    rd(DIVIDER_OFFSET, 8'hFF);
    rd(CONTROL_OFFSET, 8'h00);
    wr(3'h6, 8'h5A);
    rd(3'h6, 8'h00);
    wr(SELECT_OFFSET, 8'hF7);
    rd(SELECT_OFFSET, 8'h07);
    wr(DIVIDER_OFFSET, 8'h04);
    rd(DIVIDER_OFFSET, 8'h04);
    setup(8'h00, 8'h04, 8'h60);
    repeat (100) @(posedge i_sys_clk);
    chk(16'h0000, cnt[0] | cnt[1]);
    chk(16'h0000, {13'h0, power, tx_en, rx_en});
    for (int i = 0; i < 7; i++) begin
      setup(sel_t[i], div_t[i], ctl_t[i]);
      chk({13'h0, 1'b1, ctl_t[i][6], ctl_t[i][5]}, {13'h0, power, tx_en, rx_en});
      if (gap_t[i] == 16'h0000) begin
        repeat (200) @(posedge i_sys_clk);
        chk(16'h0000, cnt[0] | cnt[1]);
      end else begin
        for (int c = 0; c < 2; c++) begin
          if (ctl_t[i][6-c]) begin
            wait_ticks(c);
            chk(gap_t[i], gap[c]);
            chk(16'h0000, {15'h0, bad[c]});
          end
        end
        if (!ctl_t[i][6]) chk(16'h0000, cnt[0]);
        if (!ctl_t[i][5]) chk(16'h0000, cnt[1]);
        if (sel_t[i] == 8'h0B) chk(16'h0000, ext_count);
      end
    end
    // Sequence broken on purpose: both flags set, a clear while frozen is ignored
    wr(SELECT_OFFSET, 8'h00);
    wr(DIVIDER_OFFSET, 8'h03);
    i_clk_en <= 1'b0;
    wr(STATUS_OFFSET, 8'h0C);
    i_clk_en <= 1'b1;
    rd(STATUS_OFFSET, 8'hCE);
    wr(STATUS_OFFSET, 8'h0C);
    rd(STATUS_OFFSET, 8'hC2);
    sk = pick(1023);
    chk(16'h0380, {4'h0, sk});
    setup({4'h0, sk[11:8]}, sk[7:0], 8'hC0);
    wait_ticks(0);
    chk(16'h0400, gap[0]);
    results();
  end
endmodule
